// ---- design/lhr_top.sv ----
// Purpose: lin slave header receiver with auto resync and AHB-Lite registers
// Assumes: receive_line synchronous to ref_clk; single word transfers
// Notes: zero wait-state slave, always OKAY
`timescale 1ns/100ps
module lhr_top
  import lhr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic receive_line,
  output logic irq_req
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lhr_ctrl_s ctrl_q;
  lhr_hdr_e hdr_q;
  lhr_rx_e rx_q;
  lhr_meas_s meas;
  logic [DIV_W-1:0] nom_q;
  logic [DIV_W-1:0] act_q;
  logic [7:0] baud2_q;
  logic [7:0] data_q;
  logic pe_q, fe_q, lhe_q, rxne_q, hseen_q, lsf_q, sr_seen_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic rx_prev_q, armed_q, bit_q;
  logic [3:0] scnt_q;
  logic [2:0] bitn_q;
  logic [1:0] votes_q;
  logic [7:0] sh_q;
  logic chr_done_q, chr_fe_q;
  logic [7:0] chr_q;
  logic [4:0] lowcnt_q;
  logic brk_ok_q;
  logic [9:0] to_cnt_q;
  logic to_run_q;
  logic tick, meas_done, fall, maj;
  logic acc, rd_acc, wr_acc;
  logic [7:0] ra;
  logic [31:0] rd_data;
  logic wr_baud1, wr_baud2, wr_ctrl, wr_lflag;
  logic rx_run, auto_mode, brk_char, brk_det, hdr_ok, hdr_err, timeout, to_block;
  logic meas_start, meas_load, reload_fire, lsf_sw_clr, id_par_bad, in_hdr_rx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  lhr_baud_tick u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .div(act_q),
    .tick(tick)
  );

  lhr_synch_meas u_meas (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(meas_start),
    .fall(fall),
    .abort(hdr_q != H_SYNC),
    .act_div(act_q),
    .done(meas_done),
    .res(meas)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign acc = hsel && htrans[1] && hready;
  assign rd_acc = acc && !hwrite;
  assign wr_acc = acc && hwrite;
  assign ra = haddr[7:0];
  assign wr_baud1 = wr_q && (wa_q == OFF_BAUD1);
  assign wr_baud2 = wr_q && (wa_q == OFF_BAUD2);
  assign wr_ctrl = wr_q && (wa_q == OFF_CTRL);
  assign wr_lflag = wr_q && (wa_q == OFF_LFLAG);

  always_comb begin
    rd_data = 32'h00000000;
    case (ra)
      OFF_STATUS: rd_data = {26'h0, lsf_q, hseen_q, rxne_q, lhe_q, fe_q, pe_q};
      OFF_DATA: rd_data = {24'h0, data_q};
      OFF_BAUD1: rd_data = {24'h0, act_q[7:0]};
      OFF_BAUD2: rd_data = {24'h0, act_q[15:8]};
      OFF_CTRL: rd_data = {20'h0, ctrl_q};
      OFF_LFLAG: rd_data = {30'h0, lsf_q, hseen_q};
      OFF_DIV: rd_data = {16'h0, nom_q};
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_q <= wr_acc;
      wa_q <= ra;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_acc) hrdata <= rd_data;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  assign auto_mode = ctrl_q.bus_protocol_enable && ctrl_q.slave_select && ctrl_q.auto_resync_enable;
  assign in_hdr_rx = (hdr_q == H_BRK) || (hdr_q == H_DELIM) || (hdr_q == H_SYNC);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[11:0];
      if (in_hdr_rx && ctrl_q.divider_reload_select) ctrl_q.divider_reload_select <= 1'b0;
      else if (reload_fire) ctrl_q.divider_reload_select <= 1'b0;
      if (hdr_ok) ctrl_q.receiver_mute <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  assign reload_fire = ctrl_q.divider_reload_select && (hdr_q == H_IDLE) && (rx_q == R_IDLE)
                       && tick && armed_q && !receive_line;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      baud2_q <= 8'h00;
      nom_q <= DIV_RST;
      act_q <= DIV_RST;
    end else begin
      if (wr_baud2) baud2_q <= hwdata[7:0];
      if (wr_baud1) begin
        nom_q <= {baud2_q, hwdata[7:0]};
        act_q <= {baud2_q, hwdata[7:0]};
      end else if (meas_load) begin
        act_q <= meas.div;
      end else if (reload_fire) begin
        act_q <= nom_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // character receiver
  // ---------------------------------------------------------------
  assign fall = rx_prev_q && !receive_line;
  assign maj = ({1'b0, votes_q} + {2'b00, receive_line}) >= 3'h2;
  assign rx_run = ctrl_q.receiver_enable && ctrl_q.bus_protocol_enable
                  && !(hdr_q == H_SYNC && auto_mode);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_q <= R_IDLE;
      rx_prev_q <= 1'b1;
      armed_q <= 1'b0;
      bit_q <= 1'b1;
      scnt_q <= 4'h0;
      bitn_q <= 3'h0;
      votes_q <= 2'h0;
      sh_q <= 8'h00;
      chr_done_q <= 1'b0;
      chr_fe_q <= 1'b0;
      chr_q <= 8'h00;
    end else begin
      rx_prev_q <= receive_line;
      chr_done_q <= 1'b0;
      if (!rx_run) begin
        rx_q <= R_IDLE;
        armed_q <= 1'b0;
      end else if (tick) begin
        if (rx_q == R_IDLE) begin
          scnt_q <= 4'h0;
          votes_q <= 2'h0;
          if (receive_line) armed_q <= 1'b1;
          else if (armed_q) begin
            rx_q <= R_START;
            armed_q <= 1'b0;
          end
        end else begin
          scnt_q <= scnt_q + 4'h1;
          if (scnt_q >= SMP_A && scnt_q < SMP_C && receive_line) votes_q <= votes_q + 2'h1;
          if (scnt_q == SMP_C) bit_q <= maj;
          if (scnt_q == OVS_LAST) votes_q <= 2'h0;
          case (rx_q)
            R_START: begin
              if (scnt_q == OVS_LAST) begin
                rx_q <= bit_q ? R_IDLE : R_DATA;
                bitn_q <= 3'h0;
              end
            end
            R_DATA: begin
              if (scnt_q == OVS_LAST) begin
                sh_q <= {bit_q, sh_q[7:1]};
                bitn_q <= bitn_q + 3'h1;
                if (bitn_q == 3'h7) rx_q <= R_STOP;
              end
            end
            R_STOP: begin
              if (scnt_q == SMP_C) begin
                chr_done_q <= 1'b1;
                chr_q <= sh_q;
                chr_fe_q <= !maj;
                rx_q <= R_IDLE;
              end
            end
            default: rx_q <= R_IDLE;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // header sequencing
  // ---------------------------------------------------------------
  assign brk_char = chr_done_q && chr_fe_q && (chr_q == 8'h00);
  assign brk_det = ((hdr_q == H_IDLE) && brk_char && !ctrl_q.break_length_select)
                   || ((hdr_q == H_BRK) && tick && !receive_line && !brk_ok_q
                       && (lowcnt_q == BRK_EXTRA));
  assign timeout = to_run_q && tick && (to_cnt_q == HDR_LIMIT);
  assign to_block = timeout && (hdr_q == H_SYNC) && auto_mode;
  assign meas_start = (hdr_q == H_DELIM) && fall && (lowcnt_q >= DELIM_MIN) && auto_mode;
  assign meas_load = (hdr_q == H_SYNC) && auto_mode && meas_done && !meas.dev_err && !meas.ovf;
  assign id_par_bad = (chr_q[6] != (chr_q[0] ^ chr_q[1] ^ chr_q[2] ^ chr_q[4]))
                      || (chr_q[7] != !(chr_q[1] ^ chr_q[3] ^ chr_q[4] ^ chr_q[5]));
  assign hdr_ok = (hdr_q == H_ID) && chr_done_q && !chr_fe_q;
  assign lsf_sw_clr = wr_lflag && !hwdata[LF_SYNCH] && lsf_q && (hdr_q == H_SYNC);

  always_comb begin
    hdr_err = 1'b0;
    case (hdr_q)
      H_DELIM: hdr_err = fall && (lowcnt_q < DELIM_MIN);
      H_SYNC: begin
        if (auto_mode) hdr_err = meas_done && (meas.dev_err || meas.ovf);
        else hdr_err = chr_done_q && (chr_fe_q || chr_q != SYNCH_BYTE);
      end
      H_ID: hdr_err = chr_done_q && chr_fe_q;
      default: hdr_err = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hdr_q <= H_IDLE;
      lowcnt_q <= 5'h00;
      brk_ok_q <= 1'b0;
    end else if (!(ctrl_q.bus_protocol_enable && ctrl_q.slave_select)) begin
      hdr_q <= H_IDLE;
    end else if (timeout && !hdr_ok) begin
      hdr_q <= to_block ? H_BLOCK : H_IDLE;
    end else if (hdr_err) begin
      hdr_q <= H_IDLE;
    end else begin
      case (hdr_q)
        H_IDLE: begin
          if (brk_char) begin
            hdr_q <= H_BRK;
            lowcnt_q <= 5'h00;
            brk_ok_q <= !ctrl_q.break_length_select;
          end
        end
        H_BRK: begin
          if (tick) begin
            if (!receive_line) begin
              if (lowcnt_q != BRK_EXTRA) lowcnt_q <= lowcnt_q + 5'h01;
              else brk_ok_q <= 1'b1;
            end else begin
              hdr_q <= brk_ok_q ? H_DELIM : H_IDLE;
              lowcnt_q <= 5'h01; // first high sample counts
            end
          end
        end
        H_DELIM: begin
          if (fall) hdr_q <= H_SYNC;
          else if (tick && receive_line && lowcnt_q < DELIM_MIN) lowcnt_q <= lowcnt_q + 5'h01;
        end
        H_SYNC: begin
          if (meas_load || (!auto_mode && chr_done_q)) hdr_q <= H_ID;
        end
        H_ID: begin
          if (chr_done_q) hdr_q <= H_IDLE;
        end
        H_BLOCK: begin
          if (!lsf_q) hdr_q <= H_IDLE;
        end
        default: hdr_q <= H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // header time-out
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      to_run_q <= 1'b0;
      to_cnt_q <= 10'h000;
    end else if (brk_det) begin
      to_run_q <= 1'b1;
      to_cnt_q <= 10'h000;
    end else if (hdr_ok || hdr_err || timeout || lsf_sw_clr) begin
      to_run_q <= 1'b0;
    end else if (to_run_q && tick) begin
      to_cnt_q <= to_cnt_q + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // flags and data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      lhe_q <= 1'b0;
      rxne_q <= 1'b0;
      hseen_q <= 1'b0;
      lsf_q <= 1'b0;
      sr_seen_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      if (acc && ra == OFF_STATUS) sr_seen_q <= 1'b1;
      else if (rd_acc && ra == OFF_DATA) sr_seen_q <= 1'b0;
      if (rd_acc && ra == OFF_DATA) begin
        rxne_q <= 1'b0;
        if (sr_seen_q) begin
          lhe_q <= 1'b0;
          pe_q <= 1'b0;
          fe_q <= 1'b0;
        end
      end
      if (wr_lflag && !hwdata[LF_HSEEN]) hseen_q <= 1'b0;
      if (wr_lflag && !hwdata[LF_SYNCH]) lsf_q <= 1'b0;
      if (brk_det) lsf_q <= 1'b1;
      if (to_block) lsf_q <= 1'b1;
      else if ((hdr_q == H_SYNC) && (meas_load || (!auto_mode && chr_done_q && !hdr_err))) lsf_q <= 1'b0;
      if (hdr_err || timeout && !hdr_ok) lhe_q <= 1'b1;
      if (hdr_ok) begin
        hseen_q <= 1'b1;
        data_q <= chr_q;
        if (ctrl_q.parity_check_enable && id_par_bad) pe_q <= 1'b1;
      end
      if ((hdr_q == H_IDLE) && chr_done_q && !brk_char && !ctrl_q.receiver_mute) begin
        data_q <= chr_q;
        rxne_q <= 1'b1;
        if (chr_fe_q) fe_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= (hseen_q && ctrl_q.header_irq_enable)
                 || (pe_q && ctrl_q.parity_irq_enable)
                 || ((lhe_q || rxne_q) && ctrl_q.receive_irq_enable);
    end
  end
endmodule : lhr_top

// ---- design/lhr_pkg.sv ----
// Purpose: constants and carriers for the lin slave header receiver
// Assumes: 250 MHz ref_clk, AHB-Lite register port, 16x oversampling
// Notes: offsets are byte addresses; one register per aligned word
// Operation
// - valid header sets header seen, loads identifier, may interrupt
// - bad identifier parity sets parity error with header seen, may interrupt
// - identifier is third character counting break; parity in top two bits
// - header error requests interrupt when receive interrupt enabled
// - header error clears only by status access then data read
// - short delimiter, bad synch byte, framing or timeout set header error
// - header longer than 57 bit times times out; 57 or less does not
// - timeout starts at break; stops on identifier, other error, flag clear
// - synch timeout with resync blocks with flag set; else restart search
// - muted synch error or timeout flags error, stays muted, seeks header
// - muted framing error on ordinary character is dropped silently
// - valid break, synch, identifier and no timeout wake from mute
// - resync counts clocks over five falling edges, loads divider
// - receiver halts and stores nothing during synch measurement
// - nominal, measured and active dividers are kept separately
// - software nominal write wins over measured load in same cycle
// - whole synch deviation above 14.45 percent flags error
// - single interval shorter by over 17.19 percent flags error
// - reload bit or baud write reloads nominal divider
// - reload bit during break or synch is cleared and ignored
// - resync also flags deviation and measurement overflow
// - break is 10 or 11 low bits followed by delimiter
// - 16 samples per bit, majority of 8th, 9th and 10th
package lhr_pkg;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned SM_W = 19;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [4:0] DELIM_MIN = 5'h10;
  localparam logic [4:0] BRK_EXTRA = 5'h0f;
  localparam logic [9:0] HDR_LIMIT = 10'h390;
  localparam logic [7:0] SYNCH_BYTE = 8'h55;
  localparam logic [5:0] D1_NUM = 6'h25;
  localparam logic [5:0] D2_NUM = 6'h2c;
  localparam logic [15:0] DIV_RST = 16'h0010;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_BAUD1 = 8'h08;
  localparam logic [7:0] OFF_BAUD2 = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_LFLAG = 8'h14;
  localparam logic [7:0] OFF_DIV = 8'h18;
  localparam int unsigned LF_HSEEN = 0;
  localparam int unsigned LF_SYNCH = 1;
  localparam logic [11:0] CTRL_RST = 12'h000;

  typedef struct packed {
    logic receive_irq_enable;
    logic parity_irq_enable;
    logic header_irq_enable;
    logic receiver_enable;
    logic transmitter_enable;
    logic divider_reload_select;
    logic receiver_mute;
    logic break_length_select;
    logic parity_check_enable;
    logic auto_resync_enable;
    logic slave_select;
    logic bus_protocol_enable;
  } lhr_ctrl_s;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic dev_err;
    logic ovf;
  } lhr_meas_s;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_BRK = 6'h02,
    H_DELIM = 6'h04,
    H_SYNC = 6'h08,
    H_ID = 6'h10,
    H_BLOCK = 6'h20
  } lhr_hdr_e;

  typedef enum logic [3:0] {
    R_IDLE = 4'h1,
    R_START = 4'h2,
    R_DATA = 4'h4,
    R_STOP = 4'h8
  } lhr_rx_e;
endpackage : lhr_pkg

// ---- design/lhr_baud_tick.sv ----
// Purpose: sixteenth-bit sample strobe from the active divider
// Assumes: divider holds clocks per bit
// Notes: divider below 16 runs at one sample per clock
`timescale 1ns/100ps
module lhr_baud_tick
  import lhr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-5:0] cnt_q;
  logic [DIV_W-5:0] top;

  assign top = (div[DIV_W-1:4] == '0) ? {{(DIV_W-5){1'b0}}, 1'b1} : div[DIV_W-1:4];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q >= top - {{(DIV_W-5){1'b0}}, 1'b1}) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(DIV_W-5){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule : lhr_baud_tick

// ---- design/lhr_synch_meas.sv ----
// Purpose: synch field timing over five falling edges
// Assumes: start marks the first falling edge of the synch byte
// Notes: result and done are registered
`timescale 1ns/100ps
module lhr_synch_meas
  import lhr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic fall,
  input wire logic abort,
  input wire logic [DIV_W-1:0] act_div,
  output logic done,
  output lhr_meas_s res
);
  logic busy_q;
  logic ovf_q;
  logic d2_q;
  logic [2:0] edges_q;
  logic [SM_W-1:0] sm_q;
  logic [SM_W-1:0] ivl_q;
  logic [SM_W-1:0] ref8;
  logic [SM_W-1:0] dif;
  logic [SM_W+5:0] tol1;
  logic [SM_W+5:0] two;
  logic [SM_W-1:0] imin;
  logic short_ivl;

  always_comb begin
    ref8 = {act_div, 3'h0};
    dif = (sm_q > ref8) ? sm_q - ref8 : ref8 - sm_q;
    tol1 = ({6'h00, ref8} * {19'h00000, D1_NUM}) >> 8;
    two = {8'h00, act_div, 1'b0};
    imin = two[SM_W-1:0] - SM_W'((two * {19'h00000, D2_NUM}) >> 8);
    short_ivl = fall && (ivl_q < imin);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      ovf_q <= 1'b0;
      d2_q <= 1'b0;
      edges_q <= 3'h0;
      sm_q <= '0;
      ivl_q <= '0;
      done <= 1'b0;
      res <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        ovf_q <= 1'b0;
        d2_q <= 1'b0;
        edges_q <= 3'h1;
        sm_q <= {{(SM_W-1){1'b0}}, 1'b1}; // start edge cycle counts
        ivl_q <= {{(SM_W-1){1'b0}}, 1'b1};
      end else if (abort) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        if (&sm_q) ovf_q <= 1'b1;
        else sm_q <= sm_q + 1'b1;
        ivl_q <= ivl_q + 1'b1;
        if (fall) begin
          ivl_q <= {{(SM_W-1){1'b0}}, 1'b1};
          d2_q <= d2_q | short_ivl;
          edges_q <= edges_q + 3'h1;
          if (edges_q == 3'h4) begin
            busy_q <= 1'b0;
            done <= 1'b1;
            res.div <= sm_q[SM_W-1:3];
            res.ovf <= ovf_q | (&sm_q);
            res.dev_err <= d2_q | short_ivl | (dif > tol1[SM_W-1:0]);
          end
        end
      end
    end
  end
endmodule : lhr_synch_meas

// ---- sim/lhr_lin_master.sv ----
// Purpose: lin master model driving header frames
// Assumes: bus idles high through its pull-up
// Notes: n_ch characters, at most two, follow break and delimiter
`timescale 1ns/100ps
module lhr_lin_master (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [15:0] bit_clks,
  input wire logic [7:0] sync_b,
  input wire logic [7:0] id_b,
  input wire logic [1:0] n_ch,
  output logic line,
  output logic busy
);
  task automatic sb(input logic b);
    line <= b;
    repeat (bit_clks) @(posedge ref_clk);
  endtask : sb
  task automatic sc(input logic [7:0] v);
    sb(1'h0);
    for (int i = 0; i < 8; i++) sb(v[i]);
    sb(1'h1);
  endtask : sc
  initial begin
    line = 1'h1;
    busy = 1'h0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'h1;
        repeat (13) sb(1'h0);
        sb(1'h1);
        if (n_ch > 2'h0) sc(sync_b);
        if (n_ch > 2'h1) sc(id_b);
        busy <= 1'h0;
      end
    end
  end
endmodule : lhr_lin_master

// ---- sim/lhr_properties.sv ----
// Purpose: port checks for lhr_top
// Assumes: single word AHB-Lite transfers
// Notes: mirrors control writes to know irq enables
`timescale 1ns/100ps
module lhr_props
  import lhr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic wr_q;
  logic [11:0] ctrl_q;
  wire logic req = hsel && htrans[1] && hready;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_q <= 1'h0;
      ctrl_q <= CTRL_RST;
    end else begin
      wr_q <= req && hwrite && haddr[7:0] == OFF_CTRL;
      if (wr_q) ctrl_q <= hwdata[11:0];
    end
  end
  sequence s_rd(logic [7:0] off);
    req && !hwrite && haddr[7:0] == off;
  endsequence
  sequence s_quiet;
    (ctrl_q[11:9] == 3'h0) [*2];
  endsequence
  AST_OKAY: assert property (hresp == 1'h0)
    else $error("hresp not okay");
  AST_READY: assert property ($past(rstn) |-> hreadyout)
    else $error("hreadyout low after reset");
  AST_UNMAP: assert property (req && !hwrite && haddr[7:2] > 6'h06 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_DATA: assert property (s_rd(OFF_DATA) |=> hrdata[31:8] == 24'h0)
    else $error("data read too wide");
  // mute and reload bits are cleared by hardware
  AST_CTRL: assert property (s_rd(OFF_CTRL) |=> (hrdata & 32'hffffff9f) == $past({20'h0, ctrl_q & 12'hf9f}))
    else $error("control readback wrong");
  AST_NOM: assert property (s_rd(OFF_DIV) |=> hrdata[31:16] == 16'h0)
    else $error("nominal read too wide");
  AST_IRQ_MASK: assert property (s_quiet |-> !irq_req)
    else $error("irq with all enables off");
  AST_IRQ_SRC: assert property ($rose(irq_req) |-> $past(ctrl_q[11:9]) != 3'h0)
    else $error("irq without enable");
endmodule : lhr_props
bind lhr_top lhr_props i_props (.ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .irq_req);

// ---- sim/lhr_top_tb.sv ----
// Purpose: self-checking bench for lhr_top
// Assumes: divider of 32 clocks per bit
// Notes: master model drives receive_line
`timescale 1ns/100ps
module lhr_top_tb
  import lhr_pkg::*;
;
  localparam logic [31:0] DIV = 32'h20;
  logic ref_clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0;
  logic [1:0] htrans = 2'h0, n_ch = 2'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [15:0] bit_clks = 16'h0020;
  logic [7:0] sync_b = 8'h55, id_b = 8'h3c;
  logic hreadyout, hresp, receive_line, irq_req, busy;
  wire logic hready = hreadyout;
  int fails = 0;
  int total_checks = 0;
  lhr_top i_dut (.ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .receive_line, .irq_req);
  lhr_lin_master i_master (.ref_clk, .go, .bit_clks, .sync_b, .id_b, .n_ch,
    .line(receive_line), .busy);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hw;
    int n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'h1 && n < 64);
    if (hready !== 1'h1) begin
      fails++;
      summarize;
    end
  endtask : hw
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hw;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    r = hrdata;
  endtask : bus
  task automatic hdr(input logic [7:0] s, input logic [7:0] i, input logic [1:0] n);
    int k = 0;
    sync_b <= s;
    id_b <= i;
    n_ch <= n;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (busy !== 1'h0 && k < 20000);
    if (busy !== 1'h0) begin
      fails++;
      summarize;
    end
    repeat (40) @(posedge ref_clk);
  endtask : hdr
  task automatic t_regs;
    bus(1'h0, OFF_CTRL);
    chk(r, {20'h0, CTRL_RST});
    bus(1'h0, OFF_DIV);
    chk(r, {16'h0, DIV_RST});
    bus(1'h1, 8'h40, 32'hffff);
    bus(1'h0, 8'h40);
    chk(r, 32'h0);
    bus(1'h1, OFF_BAUD2);
    bus(1'h1, OFF_BAUD1, DIV);
    bus(1'h1, OFF_CTRL, 32'h180);
    bus(1'h1, OFF_CTRL, 32'h182);
    bus(1'h1, OFF_CTRL, 32'h3a3);
    bus(1'h0, OFF_DIV);
    chk(r, DIV);
  endtask : t_regs
  task automatic t_good;
    hdr(SYNCH_BYTE, 8'h3c, 2'h2);
    chk(irq_req, 1'h1);
    bus(1'h0, OFF_LFLAG);
    chk(r[0], 1'h1);
    bus(1'h0, OFF_DATA);
    chk(r, 32'h3c);
    bus(1'h0, OFF_CTRL);
    chk(r[5], 1'h0);
    bus(1'h1, OFF_LFLAG);
    repeat (2) @(posedge ref_clk);
    chk(irq_req, 1'h0);
  endtask : t_good
  task automatic t_par;
    bus(1'h1, OFF_CTRL, 32'h5ab);
    hdr(SYNCH_BYTE, 8'hbc, 2'h2);
    chk(irq_req, 1'h1);
    bus(1'h0, OFF_STATUS);
    chk({r[4], r[0]}, 2'h3);
    bus(1'h0, OFF_DATA);
    chk(r, 32'hbc);
    bus(1'h0, OFF_CTRL);
    chk(r[5], 1'h0);
    chk(irq_req, 1'h0);
    bus(1'h1, OFF_LFLAG);
  endtask : t_par
  task automatic t_synch;
    bus(1'h1, OFF_CTRL, 32'h983);
    hdr(8'h54, 8'h3c, 2'h2);
    chk(irq_req, 1'h1);
    bus(1'h0, OFF_DATA);
    bus(1'h0, OFF_LFLAG);
    chk(r[0], 1'h0);
    chk(irq_req, 1'h1);
    bus(1'h0, OFF_STATUS);
    chk(r[2], 1'h1);
    bus(1'h0, OFF_DATA);
    repeat (2) @(posedge ref_clk);
    chk(irq_req, 1'h0);
  endtask : t_synch
  task automatic t_tout;
    hdr(SYNCH_BYTE, 8'h3c, 2'h0);
    repeat (46 * DIV) @(posedge ref_clk);
    bus(1'h0, OFF_STATUS);
    chk(r[2], 1'h0);
    repeat (14 * DIV) @(posedge ref_clk);
    bus(1'h0, OFF_STATUS);
    chk(r[2], 1'h1);
    bus(1'h0, OFF_DATA);
  endtask : t_tout
  task automatic t_resync;
    bus(1'h1, OFF_CTRL, 32'h187);
    bit_clks <= 16'h0022;
    hdr(SYNCH_BYTE, 8'h3c, 2'h2);
    bus(1'h0, OFF_BAUD1);
    chk(r, 32'h22);
    bus(1'h0, OFF_DIV);
    chk(r, DIV);
    bus(1'h0, OFF_LFLAG);
    chk(r[0], 1'h1);
    bus(1'h1, OFF_BAUD2);
    bus(1'h1, OFF_BAUD1, DIV);
    bus(1'h0, OFF_BAUD1);
    chk(r, DIV);
    bit_clks <= 16'h0028;
    hdr(SYNCH_BYTE, 8'h3c, 2'h2);
    bus(1'h0, OFF_STATUS);
    chk(r[2], 1'h1);
  endtask : t_resync
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    t_regs;
    t_good;
    t_par;
    t_synch;
    t_tout;
    t_resync;
    summarize;
  end
endmodule : lhr_top_tb
